/* File: rtl/bridge_pm_pkg.sv */
// Constants, field layouts and carrier types for the bridge power-management registers.
// Assumes a 100 MHz configuration clock and 16-bit configuration accesses.
package bridge_pm_pkg;

    // Register byte offsets in configuration space.
    localparam logic [7:0]  CAP_OFFSET        = 8'hDE;
    localparam logic [7:0]  CSR_OFFSET        = 8'hE0;

    // Capability register field positions.
    localparam int          CAP_PME_MSB       = 15;
    localparam int          CAP_PME_LSB       = 11;
    localparam int          CAP_D2_BIT        = 10;
    localparam int          CAP_D1_BIT        = 9;
    localparam int          CAP_VER_MSB       = 2;
    localparam int          CAP_VER_LSB       = 0;
    localparam logic [2:0]  CAP_VER_REV10     = 3'h1;
    localparam logic [2:0]  CAP_VER_REV11     = 3'h2;

    // Control/status register field positions and reset value.
    localparam int          CSR_STATE_MSB     = 1;
    localparam int          CSR_STATE_LSB     = 0;
    localparam logic [15:0] CSR_RESET         = 16'h0000;

    // Byte-enable lanes of a 16-bit access.
    localparam int          BE_LOW            = 0;

    // Internal function reset raised on leaving the deepest state for D0.
    localparam int          CLK_PERIOD_NS     = 10;
    localparam int          INT_RESET_TIME_NS = 100;
    localparam int          INT_RESET_CYCLES  = (INT_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  INT_RESET_COUNT   = 4'(INT_RESET_CYCLES);

    typedef enum logic [1:0] {
        PS_D0    = 2'b00,
        PS_D1    = 2'b01,
        PS_D2    = 2'b10,
        PS_D3HOT = 2'b11
    } power_state_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [1:0]  be;
        logic [15:0] wdata;
    } cfg_req_s;

    typedef struct packed {
        logic        ack;
        logic [15:0] rdata;
    } cfg_rsp_s;

endpackage

/* File: rtl/bridge_power_mgmt_regs.sv */
// Power-management capability and control/status registers of the bridge function.
// Assumes single-cycle configuration strobes synchronous to clk and static mode straps.

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - PME support field, bits 15 to 11 of capabilities, always reads zero.
// - D2 support bit reads 1 when strap zero low, else 0.
// - D1 support bit reads 1 when strap zero low, else 0.
// - Capability bits 8 to 6 read as zero.
// - Device specific initialization bit reads zero.
// - Auxiliary power and PME clock bits read zero.
// - Version field reads 001 with strap zero high, 010 when low.
// - PME status bit of control/status always reads zero.
// - Data scale field reads constant 00.
// - Data select field reads constant 0000.
// - PME enable bit always reads zero.
// - Control/status bits 7 to 2 read as zero.
// - Software writes and reads back the two-bit power state; 00 D0 to 11 D3hot.
// - Control/status contents survive the internal reset on leaving D3hot for D0.
// - All power states supported with both straps low; D1 and D2 not with strap zero high; only D0 with strap one high.
// - After reset control/status reads 0000h, power state D0.
// - Secondary clocks stop in D3hot only with clock-control strap high, which also holds the state at D0, so they always run.
module bridge_power_mgmt_regs (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire bridge_pm_pkg::cfg_req_s    cfg_req,
    input  wire logic                       mode_strap_zero,
    input  wire logic                       mode_strap_one,
    output bridge_pm_pkg::cfg_rsp_s         cfg_rsp,
    output bridge_pm_pkg::power_state_e     power_state,
    output logic                            sec_clk_en,
    output logic                            func_reset
);
    import bridge_pm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Strap capture.

    logic         strap_taken;
    logic         next_strap_taken;
    logic         strap_zero;
    logic         next_strap_zero;
    logic         strap_one;
    logic         next_strap_one;
    logic         bus_clock_ctrl_strap;

    // Straps may not hold a constant under an asynchronous reset, so they are caught by
    // the first clock edge after release and held from then on.
    always_comb begin
        next_strap_taken = 1'b1;
        next_strap_zero  = strap_zero;
        next_strap_one   = strap_one;
        if (!strap_taken) begin
            next_strap_zero = mode_strap_zero;
            next_strap_one  = mode_strap_one;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_taken <= 1'b0;
            strap_zero  <= 1'b0;
            strap_one   <= 1'b0;
        end else begin
            strap_taken <= next_strap_taken;
            strap_zero  <= next_strap_zero;
            strap_one   <= next_strap_one;
        end
    end

    // The clock-control strap shares its pin with mode strap one.
    assign bus_clock_ctrl_strap = strap_one;

    ////////////////////////////////////////////////////////////////////////////////
    // Register images.

    function automatic logic [15:0] cap_image(input logic ms0);
        logic [15:0] v;
        v = 16'h0000;
        v[CAP_PME_MSB:CAP_PME_LSB] = 5'h00;
        v[CAP_D2_BIT]              = ~ms0;
        v[CAP_D1_BIT]              = ~ms0;
        v[8:6]                     = 3'h0;
        v[5]                       = 1'b0;
        v[4:3]                     = 2'h0;
        v[CAP_VER_MSB:CAP_VER_LSB] = ms0 ? CAP_VER_REV10 : CAP_VER_REV11;
        return v;
    endfunction

    function automatic logic [15:0] csr_image(input power_state_e ps);
        logic [15:0] v;
        v = CSR_RESET;
        v[15]    = 1'b0;
        v[14:13] = 2'h0;
        v[12:9]  = 4'h0;
        v[8]     = 1'b0;
        v[7:2]   = 6'h00;
        v[CSR_STATE_MSB:CSR_STATE_LSB] = ps;
        return v;
    endfunction

    // A state may be entered only if this strapping supports it.
    function automatic logic state_allowed(input logic [1:0] req, input logic ms0, input logic ms1);
        logic ok;
        ok = 1'b0;
        if (ms1) begin
            ok = (req == PS_D0);
        end else if (req == PS_D1 || req == PS_D2) begin
            ok = ~ms0;
        end else begin
            ok = 1'b1;
        end
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Power state and internal function reset.

    power_state_e state;
    power_state_e next_state;
    logic [3:0]   reset_count;
    logic [3:0]   next_reset_count;
    logic         csr_write;
    logic [1:0]   req_state;

    // Only the low byte lane reaches the writable field; every other bit has no storage.
    assign csr_write = cfg_req.wr && (cfg_req.addr == CSR_OFFSET) && cfg_req.be[BE_LOW];
    assign req_state = cfg_req.wdata[CSR_STATE_MSB:CSR_STATE_LSB];

    always_comb begin
        next_state       = state;
        next_reset_count = reset_count;
        if (reset_count != 4'h0) begin
            next_reset_count = reset_count - 4'h1;
        end
        if (csr_write && state_allowed(req_state, strap_zero, strap_one)) begin
            next_state = power_state_e'(req_state);
            if (state == PS_D3HOT && req_state == PS_D0) begin
                next_reset_count = INT_RESET_COUNT;
            end
        end
    end

    // The state register sits only on the bus reset; the internal reset that follows
    // D3hot to D0 drives func_reset outward and never clears it.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state       <= power_state_e'(CSR_RESET[CSR_STATE_MSB:CSR_STATE_LSB]);
            reset_count <= 4'h0;
        end else begin
            state       <= next_state;
            reset_count <= next_reset_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs toward the rest of the bridge.

    logic next_sec_clk_en;
    logic next_func_reset;

    always_comb begin
        next_sec_clk_en = !(bus_clock_ctrl_strap && next_state == PS_D3HOT);
        next_func_reset = (next_reset_count != 4'h0);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            power_state <= PS_D0;
            sec_clk_en  <= 1'b1;
            func_reset  <= 1'b0;
        end else begin
            power_state <= next_state;
            sec_clk_en  <= next_sec_clk_en;
            func_reset  <= next_func_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration answers.

    cfg_rsp_s next_rsp;

    // Unmapped offsets answer with zero data so software never waits on a read.
    always_comb begin
        next_rsp.ack   = cfg_req.rd || cfg_req.wr;
        next_rsp.rdata = 16'h0000;
        if (cfg_req.rd) begin
            if (cfg_req.addr == CAP_OFFSET) begin
                next_rsp.rdata = cap_image(strap_zero);
            end else if (cfg_req.addr == CSR_OFFSET) begin
                next_rsp.rdata = csr_image(state);
            end else begin
                next_rsp.rdata = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_rsp <= '0;
        end else begin
            cfg_rsp <= next_rsp;
        end
    end

endmodule

/* File: sim/bridge_pm_assertions.sv */
// Checker for the power-management register block.
// Assumes the straps stay static while out of reset.
module bridge_pm_assertions (
    input wire logic                       clk,
    input wire logic                       rst_b,
    input wire bridge_pm_pkg::cfg_req_s    cfg_req,
    input wire logic                       mode_strap_zero,
    input wire logic                       mode_strap_one,
    input wire bridge_pm_pkg::cfg_rsp_s    cfg_rsp,
    input wire bridge_pm_pkg::power_state_e power_state,
    input wire logic                       sec_clk_en,
    input wire logic                       func_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    import bridge_pm_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire cap_rd = cfg_req.rd && !cfg_req.wr && cfg_req.addr == CAP_OFFSET;
    wire csr_rd = cfg_req.rd && !cfg_req.wr && cfg_req.addr == CSR_OFFSET;
    wire st_wr  = cfg_req.wr && cfg_req.addr == CSR_OFFSET && cfg_req.be[BE_LOW];
////////////////////////////////////////
    cap_zero_a: assert property (cap_rd |=> cfg_rsp.rdata[15:11] == 5'h00 && cfg_rsp.rdata[8:3] == 6'h00)
        else $error("capability constant bits not zero");
    cap_strap_a: assert property (cap_rd |=> cfg_rsp.rdata[10:9] == {2{!mode_strap_zero}}
        && cfg_rsp.rdata[2:0] == (mode_strap_zero ? CAP_VER_REV10 : CAP_VER_REV11)) else $error("strap fields wrong");
    csr_read_a: assert property (csr_rd |=> cfg_rsp.rdata == {14'h0000, power_state})
        else $error("control/status read wrong");
    ack_once_a: assert property ((cfg_req.rd || cfg_req.wr) |=> cfg_rsp.ack) else $error("missing ack");
    state_hold_a: assert property (!st_wr |=> $stable(power_state)) else $error("state moved without write");
    clk_gate_a: assert property (sec_clk_en == !(mode_strap_one && power_state == PS_D3HOT))
        else $error("secondary clock enable wrong");
    strap_state_a: assert property (mode_strap_one |-> power_state == PS_D0) else $error("state with strap one");
    freset_cause_a: assert property ($rose(func_reset) |-> $past(power_state) == PS_D3HOT && power_state == PS_D0)
        else $error("internal reset without exit from deepest state");
    freset_len_a: assert property ($rose(func_reset) |-> ##9 func_reset ##1 !func_reset)
        else $error("internal reset length wrong");
    cover property (cap_rd);
    cover property (power_state == PS_D3HOT);
    cover property ($rose(func_reset));
endmodule
bind bridge_power_mgmt_regs bridge_pm_assertions bridge_pm_assertions_inst (.clk, .rst_b, .cfg_req,
    .mode_strap_zero, .mode_strap_one, .cfg_rsp, .power_state, .sec_clk_en, .func_reset);

/* File: sim/test_bridge_power_mgmt_regs.sv */
// Self-checking bench for the power-management register block.
// Drives straps and configuration strobes itself on the falling edge.
module test_bridge_power_mgmt_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import bridge_pm_pkg::*;
    typedef struct packed {
        logic [1:0]  straps;
        logic [7:0]  addr;
        logic [1:0]  be;
        logic [15:0] wdata;
        logic [15:0] exp;
    } row_s;
    logic         clk, rst_b, mode_strap_zero, mode_strap_one, sec_clk_en, func_reset;
    cfg_req_s     cfg_req;
    cfg_rsp_s     cfg_rsp;
    power_state_e power_state;
    int           failures, tests_run, n;
    logic [15:0]  rd_val;
    // Straps are latched only on the first clock edge after reset, so a strap change in the table forces a fresh reset.
    row_s rows [10] = '{'{2'b01, 8'hDE, 2'h3, 16'hFFFF, 16'h0001},
        '{2'b01, 8'hE0, 2'h3, 16'h0002, 16'h0000}, '{2'b01, 8'hE0, 2'h3, 16'h0003, 16'h0003},
        '{2'b10, 8'hE0, 2'h3, 16'h0003, 16'h0000}, '{2'b10, 8'hDE, 2'h3, 16'h0000, 16'h0602},
        '{2'b00, 8'hE0, 2'h3, 16'hFFFD, 16'h0001}, '{2'b00, 8'hE0, 2'h2, 16'h0002, 16'h0001},
        '{2'b00, 8'hE0, 2'h1, 16'h0002, 16'h0002}, '{2'b00, 8'h40, 2'h3, 16'hFFFF, 16'h0000},
        '{2'b00, 8'hE0, 2'h1, 16'hFF03, 16'h0003}};
    bridge_power_mgmt_regs bridge_power_mgmt_regs_inst (.clk, .rst_b, .cfg_req, .mode_strap_zero,
        .mode_strap_one, .cfg_rsp, .power_state, .sec_clk_en, .func_reset);
////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
        @(negedge clk);
        cfg_req = '{w, !w, a, be, d};
        @(negedge clk);
        cfg_req = '0;
        chk(16'(cfg_rsp.ack), 16'h0001);
        rd_val = cfg_rsp.rdata;
    endtask
    task automatic restart(input logic [1:0] s);
        @(negedge clk);
        rst_b = 1'b0;
        {mode_strap_one, mode_strap_zero} = s;
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        acc(1'b0, CSR_OFFSET, 2'h3, 16'h0000);
        chk(rd_val, CSR_RESET);
        $display("reset test done, straps %b", s);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        failures = 0;
        tests_run = 0;
        cfg_req = '0;
        rst_b = 1'b0;
        {mode_strap_one, mode_strap_zero} = 2'b00;
        for (int i = 0; i < 10; i++) begin
            if (i == 0 || rows[i].straps != rows[i - 1].straps) begin
                restart(rows[i].straps);
            end
            acc(1'b1, rows[i].addr, rows[i].be, rows[i].wdata);
            acc(1'b0, rows[i].addr, 2'h3, 16'h0000);
            chk(rd_val, rows[i].exp);
        end
        $display("row table done");
        chk(16'(sec_clk_en), 16'h0001);
        acc(1'b1, CSR_OFFSET, 2'h1, 16'h0000);
        n = 0;
        for (int k = 0; k < 20; k++) begin
            if (func_reset === 1'b1) begin
                n++;
            end
            @(negedge clk);
        end
        chk(16'(n), 16'(INT_RESET_CYCLES));
        acc(1'b0, CSR_OFFSET, 2'h3, 16'h0000);
        chk(rd_val, 16'h0000);
        $display("internal reset test done");
        print_verdict();
    end
endmodule
